// file: design/fbrc_cmd_top.sv
// Functional notes
// - Format selector default 0, values 0 to 4
// - Format taken once after reset only
// - Reverse bit runs reverse, low means stop
// - General bits 1-4 pick multistep speed
// - General bits 5-6 pick ramp/regulator set
// - Each general bit function is reassignable
// - General bit 7 default is error reset
// - General bit 8 default is coast stop
// - Monitor request loads word, then acknowledges
// - Speed request copies word to volatile speed
// - Speed write done raises its acknowledge
// - Execute request runs the command code
// - Command done raises its acknowledge
// - Failed command gives nonzero result word
// - Alarm reset request clears active alarm
// - Monitor word refreshed while request held
// - Speed word reapplied while request held
// - Command re-executed while request held
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "fbrc_params.svh"

module fbrc_cmd_top
    import fbrc_pkg::*;
#(
    parameter int TABLE_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output var  logic [31:0] regRdData,
    // Link side, asynchronous to core_clk
    input  wire logic [31:0] remoteBits,
    input  wire logic [15:0] speedCommandWord,
    input  wire logic [15:0] commandCodeWord,
    // Drive side, same clock
    input  wire logic [2:0]  linkFormatSelect,
    input  wire logic [15:0] monitorIn,
    input  wire logic        alarmEvent,
    // Decoded drive commands
    output var  logic        forwardRun,
    output var  logic        reverseRun,
    output var  logic [3:0]  multistepSpeedSelectLines,
    output var  logic [1:0]  rampParameterSetSelect,
    output var  logic        errorReset,
    output var  logic        coastStopCommand,
    // Answers toward the master
    output var  logic        monitoringAcknowledge,
    output var  logic [15:0] firstRemoteReadWord,
    output var  logic        speedWriteDoneAck,
    output var  logic [15:0] volatileSpeed,
    output var  logic        commandExecuteDoneAck,
    output var  logic [15:0] commandResultWord,
    output var  logic [15:0] commandReadWord,
    output var  logic        alarmStatus,
    output var  logic        alarmResetCommand,
    output var  logic [2:0]  linkFormat
);

    generate
        if (TABLE_DEPTH < 1 || TABLE_DEPTH > `FBRC_TABLE_MAX) begin : g_chk
            $error("fbrc_cmd_top: TABLE_DEPTH out of range");
        end
    endgenerate

    fbrc_state_t s;
    fbrc_state_t next_s;

    // Synchronised link inputs
    logic [63:0] linkSync;
    logic [31:0] ry;
    logic [15:0] spdWord;
    logic [15:0] codeWord;

    fbrc_sync3 #(
        .W (64)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({commandCodeWord, speedCommandWord, remoteBits}),
        .q        (linkSync)
    );

    assign ry       = linkSync[31:0];
    assign spdWord  = linkSync[47:32];
    assign codeWord = linkSync[63:48];

    logic fwdReq;
    logic revReq;
    logic monReq;
    logic spdReq;
    logic cmdReq;
    logic almRstReq;
    logic [7:0] genBits;

    assign fwdReq    = ry[`FBRC_BIT_FWD];
    assign revReq    = ry[`FBRC_BIT_REV];
    assign genBits   = ry[`FBRC_BIT_GEN +: 8];
    assign monReq    = ry[`FBRC_BIT_MON];
    assign spdReq    = ry[`FBRC_BIT_SPD];
    assign cmdReq    = ry[`FBRC_BIT_CMD];
    assign almRstReq = ry[`FBRC_BIT_ALMRST];

    // Per general bit: one-hot of the function it is mapped to
    logic [7:0][7:0] bitHit;

    generate
        for (genvar g = 0; g < 8; g++) begin : g_gen
            assign bitHit[g] = genBits[g] ? (8'h01 << s.funcMap[3*g +: 3]) : 8'h00;
        end
    endgenerate

    logic [7:0] fnHit;

    always_comb begin
        fnHit = 8'h00;
        for (int k = 0; k < 8; k++) begin
            fnHit = fnHit | bitHit[k];
        end
    end

    // Command code fields
    logic [3:0]  opCode;
    logic [3:0]  opIdx;
    logic [7:0]  opData;
    logic        idxOk;

    assign opCode = codeWord[`FBRC_OP_LO +: 4];
    assign opIdx  = codeWord[`FBRC_IDX_LO +: 4];
    assign opData = codeWord[7:0];
    assign idxOk  = (32'(opIdx) < TABLE_DEPTH);

    logic [15:0] monSource;

    always_comb begin
        case (s.monSel)
            `FBRC_MON_DRIVE:   monSource = monitorIn;
            `FBRC_MON_SPEED:   monSource = s.volSpeed;
            `FBRC_MON_CMDREAD: monSource = s.cxRead;
            default:           monSource = 16'h0000;
        endcase
    end

    always_comb begin
        next_s = s;

        // Format is caught once, on the first edge after reset
        if (!s.formatLatched) begin
            next_s.formatLatched = 1'b1;
            if (linkFormatSelect <= `FBRC_FORMAT_MAX) begin
                next_s.linkFormat = linkFormatSelect;
            end else begin
                next_s.linkFormat = `FBRC_FORMAT_RST;
            end
        end

        // Run direction; both at once is treated as stop
        next_s.fwdRun = fwdReq & ~revReq;
        next_s.revRun = revReq & ~fwdReq;

        // Function decode of the general bits
        next_s.speedSel  = fnHit[FN_SS8:FN_SS1];
        next_s.rampSel   = fnHit[FN_RT2:FN_RT1];
        next_s.errReset  = fnHit[FN_RST];
        next_s.coastStop = fnHit[FN_BX];

        // Monitor handshake
        if (monReq) begin
            next_s.monWord = monSource;
            next_s.monAck  = 1'b1;
        end else begin
            next_s.monAck  = 1'b0;
        end

        // Speed write handshake, acknowledge one cycle after the write
        if (spdReq) begin
            next_s.volSpeed = spdWord;
        end
        next_s.spdAck = spdReq & s.spdAck | spdReq & (s.volSpeed == spdWord);

        // Command execution handshake
        case (s.cx)
            CX_IDLE: begin
                next_s.cxAck = 1'b0;
                if (cmdReq) begin
                    next_s.cx = CX_EXEC;
                end
            end
            CX_EXEC, CX_DONE: begin
                if (cmdReq) begin
                    next_s.cx    = CX_DONE;
                    next_s.cxAck = 1'b1;
                    case (opCode)
                        `FBRC_OP_READ: begin
                            if (idxOk) begin
                                next_s.cxRead   = s.table_[opIdx];
                                next_s.cxResult = `FBRC_ERR_NONE;
                            end else begin
                                next_s.cxResult = `FBRC_ERR_IDX;
                            end
                        end
                        `FBRC_OP_WRITE: begin
                            if (idxOk) begin
                                next_s.table_[opIdx] = {8'h00, opData};
                                next_s.cxResult      = `FBRC_ERR_NONE;
                            end else begin
                                next_s.cxResult = `FBRC_ERR_IDX;
                            end
                        end
                        default: begin
                            next_s.cxResult = `FBRC_ERR_OP;
                        end
                    endcase
                end else begin
                    next_s.cx    = CX_IDLE;
                    next_s.cxAck = 1'b0;
                end
            end
            default: begin
                next_s.cx    = CX_IDLE;
                next_s.cxAck = 1'b0;
            end
        endcase

        // Alarm: a new event wins over a reset in the same cycle
        next_s.alarmResetCmd = s.alarm & almRstReq;
        if (alarmEvent) begin
            next_s.alarm = 1'b1;
        end else if (almRstReq) begin
            next_s.alarm = 1'b0;
        end

        // Register writes
        if (regWr) begin
            case (regAddr)
                `FBRC_REG_FUNCMAP: next_s.funcMap = regWrData[23:0];
                `FBRC_REG_MONSEL:  next_s.monSel  = regWrData[1:0];
                default: begin
                end
            endcase
        end

        // Register reads, data valid only in the following cycle
        next_s.rdData = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                `FBRC_REG_FORMAT:  next_s.rdData = {29'h0, s.linkFormat};
                `FBRC_REG_FUNCMAP: next_s.rdData = {8'h00, s.funcMap};
                `FBRC_REG_MONSEL:  next_s.rdData = {30'h0, s.monSel};
                `FBRC_REG_STATUS: begin
                    next_s.rdData = {24'h0, s.cx, s.alarm, s.cxAck,
                                     s.spdAck, s.monAck, s.formatLatched};
                end
                `FBRC_REG_SPEED:   next_s.rdData = {16'h0000, s.volSpeed};
                default:           next_s.rdData = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s            <= '0;
            s.linkFormat <= `FBRC_FORMAT_RST;
            s.funcMap    <= `FBRC_FUNCMAP_RST;
            s.monSel     <= `FBRC_MONSEL_RST;
            s.cx         <= CX_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign regRdData                 = s.rdData;
    assign forwardRun                = s.fwdRun;
    assign reverseRun                = s.revRun;
    assign multistepSpeedSelectLines = s.speedSel;
    assign rampParameterSetSelect    = s.rampSel;
    assign errorReset                = s.errReset;
    assign coastStopCommand          = s.coastStop;
    assign monitoringAcknowledge     = s.monAck;
    assign firstRemoteReadWord       = s.monWord;
    assign speedWriteDoneAck         = s.spdAck;
    assign volatileSpeed             = s.volSpeed;
    assign commandExecuteDoneAck     = s.cxAck;
    assign commandResultWord         = s.cxResult;
    assign commandReadWord           = s.cxRead;
    assign alarmStatus               = s.alarm;
    assign alarmResetCommand         = s.alarmResetCmd;
    assign linkFormat                = s.linkFormat;

endmodule : fbrc_cmd_top

`default_nettype wire

// file: design/fbrc_params.svh
`ifndef FBRC_PARAMS_SVH
`define FBRC_PARAMS_SVH

// Register offsets
`define FBRC_REG_FORMAT   8'h00
`define FBRC_REG_FUNCMAP  8'h04
`define FBRC_REG_MONSEL   8'h08
`define FBRC_REG_STATUS   8'h0c
`define FBRC_REG_SPEED    8'h10

// Reset values and format maximum
`define FBRC_FORMAT_RST   3'h0
`define FBRC_FORMAT_MAX   3'h4
`define FBRC_FUNCMAP_RST  24'hfac688
`define FBRC_MONSEL_RST   2'h0

// Remote output bit positions, second word starts at bit 16
`define FBRC_BIT_FWD      0
`define FBRC_BIT_REV      1
`define FBRC_BIT_GEN      2
`define FBRC_BIT_MON      12
`define FBRC_BIT_SPD      13
`define FBRC_BIT_CMD      15
`define FBRC_BIT_ALMRST   26

// Command code word fields
`define FBRC_OP_LO        12
`define FBRC_IDX_LO       8
`define FBRC_OP_READ      4'h1
`define FBRC_OP_WRITE     4'h2
`define FBRC_ERR_NONE     16'h0000
`define FBRC_ERR_OP       16'h0001
`define FBRC_ERR_IDX      16'h0002
`define FBRC_TABLE_MAX    16

// Monitor sources
`define FBRC_MON_DRIVE    2'h0
`define FBRC_MON_SPEED    2'h1
`define FBRC_MON_CMDREAD  2'h2

`endif

// file: design/fbrc_pkg.sv
`include "fbrc_params.svh"

package fbrc_pkg;

    typedef enum logic [2:0] {
        FN_SS1 = 3'h0,
        FN_SS2 = 3'h1,
        FN_SS4 = 3'h2,
        FN_SS8 = 3'h3,
        FN_RT1 = 3'h4,
        FN_RT2 = 3'h5,
        FN_RST = 3'h6,
        FN_BX  = 3'h7
    } fbrc_func_t;

    typedef enum logic [2:0] {
        CX_IDLE = 3'h1,
        CX_EXEC = 3'h2,
        CX_DONE = 3'h4
    } fbrc_cx_t;

    typedef struct packed {
        logic                                formatLatched;
        logic [2:0]                          linkFormat;
        logic [23:0]                         funcMap;
        logic [1:0]                          monSel;
        logic                                fwdRun;
        logic                                revRun;
        logic [3:0]                          speedSel;
        logic [1:0]                          rampSel;
        logic                                errReset;
        logic                                coastStop;
        logic                                monAck;
        logic [15:0]                         monWord;
        logic                                spdAck;
        logic [15:0]                         volSpeed;
        fbrc_cx_t                            cx;
        logic                                cxAck;
        logic [15:0]                         cxResult;
        logic [15:0]                         cxRead;
        logic                                alarm;
        logic                                alarmResetCmd;
        logic [31:0]                         rdData;
        logic [`FBRC_TABLE_MAX-1:0][15:0]    table_;
    } fbrc_state_t;

endpackage : fbrc_pkg

// file: design/fbrc_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module fbrc_sync3 #(
    parameter int W = 64
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Asynchronous input and filtered result
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } fbrc_sync_t;

    fbrc_sync_t s;
    fbrc_sync_t next_s;
    logic [W-1:0] agree;

    generate
        if (W < 1) begin : g_chk
            $error("fbrc_sync3: W must be at least 1");
        end
        for (genvar i = 0; i < W; i++) begin : g_bit
            // A bit moves only when stages two and three agree
            assign agree[i] = (s.s2[i] == s.s3[i]);
        end
    endgenerate

    always_comb begin
        next_s    = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.q  = (agree & s.s3) | (~agree & s.q);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.q;

endmodule : fbrc_sync3

`default_nettype wire

// file: tb/fbrc_cmd_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fbrc_cmd_top_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Register writes
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWr,
    // Link and drive inputs
    input wire logic [31:0] remoteBits,
    input wire logic [15:0] speedCommandWord,
    input wire logic [15:0] commandCodeWord,
    input wire logic        alarmEvent,
    // Outputs
    input wire logic        forwardRun,
    input wire logic        reverseRun,
    input wire logic [3:0]  multistepSpeedSelectLines,
    input wire logic [1:0]  rampParameterSetSelect,
    input wire logic        errorReset,
    input wire logic        coastStopCommand,
    input wire logic        monitoringAcknowledge,
    input wire logic        speedWriteDoneAck,
    input wire logic [15:0] volatileSpeed,
    input wire logic        commandExecuteDoneAck,
    input wire logic [15:0] commandResultWord,
    input wire logic        alarmStatus,
    input wire logic [2:0]  linkFormat
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic       remapped;
    logic [1:0] upCnt;
    // Tracks a non-default bit function map and time since reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            remapped <= 1'b0;
            upCnt    <= 2'h0;
        end else begin
            if (upCnt != 2'h3)
                upCnt <= upCnt + 2'h1;
            if (regWr && regAddr == 8'h04)
                remapped <= regWrData[23:0] != 24'hfac688;
        end
    end
    property p_fmt; linkFormat <= 3'h4; endproperty
    a_fmt: assert property (p_fmt)
        else $error("format above four");
    property p_fmt_hold; upCnt == 2'h3 |-> $stable(linkFormat); endproperty
    a_fmt_hold: assert property (p_fmt_hold)
        else $error("format changed after start");
    property p_run;
        $stable(remoteBits[1:0])[*6] |-> forwardRun == (remoteBits[1:0] == 2'b01)
            && reverseRun == (remoteBits[1:0] == 2'b10);
    endproperty
    a_run: assert property (p_run)
        else $error("run decode wrong");
    property p_gen;
        (!remapped && !$past(remapped) && $stable(remoteBits[9:2]))[*6] |-> {coastStopCommand,
            errorReset, rampParameterSetSelect, multistepSpeedSelectLines} == remoteBits[9:2];
    endproperty
    a_gen: assert property (p_gen)
        else $error("general bit decode wrong");
    property p_mon; remoteBits[12][*7] |-> monitoringAcknowledge; endproperty
    a_mon: assert property (p_mon)
        else $error("monitor ack missing");
    property p_spd;
        (remoteBits[13] && $stable(speedCommandWord))[*8] |-> speedWriteDoneAck
            && volatileSpeed == speedCommandWord;
    endproperty
    a_spd: assert property (p_spd)
        else $error("speed write not applied");
    property p_cmd; remoteBits[15][*8] |-> commandExecuteDoneAck; endproperty
    a_cmd: assert property (p_cmd)
        else $error("command ack missing");
    property p_err;
        (remoteBits[15] && $stable(commandCodeWord) && commandCodeWord[15:12] != 4'h1
            && commandCodeWord[15:12] != 4'h2)[*8] |-> commandResultWord != 16'h0;
    endproperty
    a_err: assert property (p_err)
        else $error("bad command gave zero result");
    property p_alm; (remoteBits[26] && !alarmEvent)[*7] |-> !alarmStatus; endproperty
    a_alm: assert property (p_alm)
        else $error("alarm not cleared");
    property p_ack_low;
        (!remoteBits[12] && !remoteBits[13] && !remoteBits[15])[*7] |-> !monitoringAcknowledge
            && !speedWriteDoneAck && !commandExecuteDoneAck;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("ack held without request");
    c_mon: cover property ($rose(monitoringAcknowledge));
    c_cmd: cover property ($rose(commandExecuteDoneAck));
    c_alm: cover property ($fell(alarmStatus));
endmodule : fbrc_cmd_top_asserts
bind fbrc_cmd_top fbrc_cmd_top_asserts fbrc_cmd_top_asserts_inst (.*);
`default_nettype wire

// file: tb/fbrc_cmd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fbrc_cmd_top_tb;
    localparam int DEPTH = 8;
    logic        core_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, alarmEvent = 1'b0;
    logic        snap = 1'b0, rdWas = 1'b0;
    logic [1:0]  snapSel = 2'h0;
    logic [7:0]  regAddr = 8'h0;
    logic [31:0] regWrData = 32'h0, regRdData, remoteBits, ctl;
    logic [2:0]  linkFormatSelect = 3'h0, linkFormat, g3;
    logic [15:0] monitorIn = 16'h0, speedCommandWord, commandCodeWord, w;
    logic [15:0] firstRemoteReadWord, volatileSpeed, commandResultWord, commandReadWord;
    logic        forwardRun, reverseRun, errorReset, coastStopCommand, monitoringAcknowledge;
    logic        speedWriteDoneAck, commandExecuteDoneAck, alarmStatus, alarmResetCommand;
    logic [3:0]  multistepSpeedSelectLines;
    logic [1:0]  rampParameterSetSelect;
    logic [31:0] notes[$];
    logic [15:0] codes[5] = '{16'h23a5, 16'h1300, 16'h7300, 16'h1900, 16'h0300};
    logic [31:0] exps[5] = '{32'h0, 32'ha5, 32'h100a5, 32'h200a5, 32'h100a5};
    int          n_errors = 0, compares = 0;
    assign ctl = {14'h0, linkFormat, alarmResetCommand, alarmStatus, commandExecuteDoneAck,
                  speedWriteDoneAck,
                  monitoringAcknowledge, coastStopCommand, errorReset, rampParameterSetSelect,
                  multistepSpeedSelectLines, reverseRun, forwardRun};
    fbrc_cmd_top #(.TABLE_DEPTH(DEPTH)) fbrc_cmd_top_inst (.*);
    fbrc_master_model fbrc_master_model_inst (.core_clk(core_clk),
        .monAck(monitoringAcknowledge), .spdAck(speedWriteDoneAck),
        .cmdAck(commandExecuteDoneAck), .remoteBits(remoteBits),
        .speedWord(speedCommandWord), .codeWord(commandCodeWord));
    initial forever #5 core_clk = ~core_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // Watcher: compares each appearing result with the oldest note
    always @(posedge core_clk) begin
        if (rdWas)
            check(regRdData, notes.pop_front());
        if (snap)
            check(snapSel == 2'h1 ? ctl : snapSel == 2'h2 ? {16'h0, firstRemoteReadWord}
                  : {commandResultWord, commandReadWord}, notes.pop_front());
        rdWas <= regRd;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {regWr, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        notes.push_back(exp);
        {regRd, regAddr} <= {1'b1, a};
        @(posedge core_clk);
        regRd <= 1'b0;
    endtask : rd
    task automatic snapshot(input logic [1:0] sel, input logic [31:0] exp);
        @(posedge core_clk);
        notes.push_back(exp);
        {snap, snapSel} <= {1'b1, sel};
        @(posedge core_clk);
        snap <= 1'b0;
    endtask : snapshot
    task automatic hs(input int idx, input logic [15:0] word, input int hold);
        bit ok;
        fbrc_master_model_inst.handshake(idx, word, hold, ok);
        if (!ok) begin
            n_errors++;
            print_verdict();
        end
    endtask : hs
    initial begin
        void'($urandom(32'h7f24));
        for (int f = 0; f < 6; f++) begin
            g3 = 3'(f);
            linkFormatSelect <= g3;
            rst <= 1'b1;
            repeat (8) @(posedge core_clk);
            rst <= 1'b0;
            repeat (2) @(posedge core_clk);
            linkFormatSelect <= g3 + 3'h1;
            rd(8'h00, f > 4 ? 32'h0 : {29'h0, g3});
            snapshot(2'h1, {14'h0, f > 4 ? 3'h0 : g3, 15'h0});
        end
        wr(8'h00, 32'h3);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h00fac688);
        rd(8'h14, 32'h0);
        for (int r = 0; r < 4; r++) begin
            fbrc_master_model_inst.put(32'h3, 32'(r));
            repeat (7) @(posedge core_clk);
            snapshot(2'h1, {30'h0, r == 2, r == 1});
        end
        repeat (4) begin
            w = 16'($urandom);
            fbrc_master_model_inst.put(32'h3fc, {22'h0, w[7:0], 2'h0});
            repeat (7) @(posedge core_clk);
            snapshot(2'h1, {22'h0, w[7:0], 2'h0});
        end
        wr(8'h04, 32'h00fac68f);
        fbrc_master_model_inst.put(32'h3fc, 32'h4);
        repeat (7) @(posedge core_clk);
        snapshot(2'h1, 32'h200);
        wr(8'h04, 32'h00fac688);
        fbrc_master_model_inst.put(32'h3fc, 32'h0);
        w = 16'($urandom);
        monitorIn <= w;
        fork
            hs(12, 16'h0, 8);
            begin
                repeat (9) @(posedge core_clk);
                monitorIn <= ~w;
            end
        join
        snapshot(2'h2, {16'h0, ~w});
        w = 16'($urandom);
        fork
            hs(13, w, 10);
            begin
                repeat (9) @(posedge core_clk);
                fbrc_master_model_inst.speedWord <= ~w;
            end
        join
        rd(8'h10, {16'h0, ~w});
        check({16'h0, volatileSpeed}, {16'h0, ~w});
        for (int i = 0; i < 5; i++) begin
            hs(15, codes[i], 0);
            snapshot(2'h3, exps[i]);
        end
        @(posedge core_clk);
        alarmEvent <= 1'b1;
        @(posedge core_clk);
        alarmEvent <= 1'b0;
        snapshot(2'h1, 32'h2000);
        fbrc_master_model_inst.put(32'h04000000, 32'h04000000);
        repeat (4) @(posedge core_clk);
        snapshot(2'h1, 32'h4000);
        repeat (1) @(posedge core_clk);
        snapshot(2'h1, 32'h0);
        fbrc_master_model_inst.put(32'h04000000, 32'h0);
        repeat (3) @(posedge core_clk);
        print_verdict();
    end
endmodule : fbrc_cmd_top_tb
`default_nettype wire

// file: tb/fbrc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbrc_master_model (
    // Clock
    input  wire logic        core_clk,
    // Acknowledges from the card
    input  wire logic        monAck,
    input  wire logic        spdAck,
    input  wire logic        cmdAck,
    // Cyclic data toward the card
    output var  logic [31:0] remoteBits = 32'h0,
    output var  logic [15:0] speedWord  = 16'h0,
    output var  logic [15:0] codeWord   = 16'h0
);
    // Station multiplier, fixed at 1 and never updated or used
    int unsigned stationMult = 1;
    function automatic logic ack(input int idx);
        return idx == 12 ? monAck : idx == 13 ? spdAck : cmdAck;
    endfunction : ack
    task automatic put(input logic [31:0] mask, input logic [31:0] val);
        @(posedge core_clk);
        remoteBits <= (remoteBits & ~mask) | (val & mask); // Spares stay low
    endtask : put
    // Four-phase request, with a chosen extra hold before release
    task automatic handshake(input int idx, input logic [15:0] word, input int hold,
                             output bit ok);
        int n;
        @(posedge core_clk);
        if (idx == 13)
            speedWord <= word;
        if (idx == 15)
            codeWord <= word;
        remoteBits[idx] <= 1'b1;
        for (n = 0; n < 30 && ack(idx) !== 1'b1; n++)
            @(posedge core_clk);
        ok = n < 30;
        repeat (hold) @(posedge core_clk);
        remoteBits[idx] <= 1'b0;
        for (n = 0; n < 30 && ack(idx) !== 1'b0; n++)
            @(posedge core_clk);
        ok &= n < 30;
    endtask : handshake
endmodule : fbrc_master_model
`default_nettype wire
